// ### design/sdce_cfg.svh
// Constants for the search data command engine: offsets, fields, codes, layout
`ifndef SDCE_CFG_SVH
`define SDCE_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SDCE_REG_CTRL      12'h000
`define SDCE_REG_CDB_OP    12'h004
`define SDCE_REG_CDB_LBA   12'h008
`define SDCE_REG_CDB_NBLK  12'h00C
`define SDCE_REG_BLKLEN    12'h010
`define SDCE_REG_STATUS    12'h014
`define SDCE_REG_INFO      12'h018
`define SDCE_REG_CSI       12'h01C
`define SDCE_REG_NEXT_LBA  12'h020
`define SDCE_REG_NEXT_FLG  12'h024
`define SDCE_REG_EFF_LBA   12'h028
`define SDCE_REG_PARAM     12'h100

// ----------------------------------------------------------------------
// Field positions and block length reset value
// ----------------------------------------------------------------------
`define SDCE_CTRL_START    0
`define SDCE_CTRL_LINK     1
`define SDCE_OP_RELATIVE_ADDRESS_FLAG     8
`define SDCE_OP_SPANNED    9
`define SDCE_OP_INVERT     12
`define SDCE_BLKLEN_RESET  32'h0000_0200

// ----------------------------------------------------------------------
// Opcodes, status codes, sense keys, additional sense code
// ----------------------------------------------------------------------
`define SDCE_OPC_HIGH      8'h30
`define SDCE_OPC_EQUAL     8'h31
`define SDCE_OPC_LOW       8'h32
`define SDCE_ST_GOOD       8'h00
`define SDCE_ST_CHECK      8'h02
`define SDCE_ST_COND_MET   8'h04
`define SDCE_ST_INT_MET    8'h14
`define SDCE_SK_NO_SENSE   4'h0
`define SDCE_SK_ILLEGAL    4'h5
`define SDCE_SK_EQUAL      4'hC
`define SDCE_ASC_NONE      8'h00
`define SDCE_ASC_INV_PARAM 8'h26

// ----------------------------------------------------------------------
// Parameter list layout
// ----------------------------------------------------------------------
`define SDCE_HDR_RECLEN    0
`define SDCE_HDR_FIRSTOFF  4
`define SDCE_HDR_NUMREC    8
`define SDCE_HDR_ARGLEN    12
`define SDCE_HDR_BYTES     14
`define SDCE_DSC_PLEN      4
`define SDCE_DSC_PATTERN   6

`endif

// ### design/sdce_pkg.sv
// Types shared by the search data command engine
package sdce_pkg;

    // Engine sequencing states
    typedef enum logic [3:0] {
        SDCE_IDLE,
        SDCE_CHECK,
        SDCE_PLACE,
        SDCE_DLOAD,
        SDCE_ADDR,
        SDCE_NORM,
        SDCE_FETCH,
        SDCE_DEVAL,
        SDCE_NEXTREC
    } sdce_state_t;

    // Completion status and sense summary
    typedef struct packed {
        logic [7:0] status;
        logic [3:0] senseKey;
        logic       valid;
        logic [7:0] asc;
    } sdce_result_t;

    // Media byte request
    typedef struct packed {
        logic [31:0] lba;
        logic [31:0] offset;
    } sdce_media_req_t;

endpackage

// ### design/sdce_search_engine.sv
// Search data command engine with APB registers and a byte media port
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sdce_cfg.svh"

module sdce_search_engine #(
    parameter int PARAM_BYTES = 64                    // Parameter list buffer size
) (
    input  wire logic                      clock,     // 40 MHz clock
    input  wire logic                      reset_n,   // Synchronous reset, active low
    input  wire logic                      psel,      // APB select
    input  wire logic                      penable,   // APB access phase
    input  wire logic                      pwrite,    // APB write
    input  wire logic [11:0]               paddr,     // APB byte address
    input  wire logic [31:0]               pwdata,    // APB write data
    output logic      [31:0]               prdata,    // APB read data
    output logic                           pready,    // APB ready
    output logic                           pslverr,   // APB error on unmapped address
    output logic                           mediaReq,  // Byte fetch request
    output sdce_pkg::sdce_media_req_t      mediaAddr, // Byte fetch address
    input  wire logic                      mediaAck,  // Byte fetch answered
    input  wire logic [7:0]                mediaData  // Fetched byte
);
    localparam int PW = $clog2(PARAM_BYTES);

    sdce_pkg::sdce_state_t  state_q;
    sdce_pkg::sdce_result_t result_q;
    logic [7:0]   paramMem [PARAM_BYTES];
    logic         link_q;
    logic [15:0]  cdbOp_q;
    logic [31:0]  cdbLba_q;
    logic [15:0]  cdbNblk_q;
    logic [31:0]  blkLen_q;
    logic [31:0]  nextLba_q;
    logic         nextRel_q;
    logic [31:0]  effLba_q;
    logic [31:0]  info_q;
    logic [31:0]  csi_q;
    logic         busy_q;
    logic         done_q;
    logic [31:0]  recLen_q;
    logic [31:0]  numRec_q;
    logic [15:0]  argLen_q;
    logic [15:0]  recBlk_q;
    logic [31:0]  recOff_q;
    logic [31:0]  recLeft_q;
    logic [15:0]  descPtr_q;
    logic [31:0]  disp_q;
    logic [15:0]  plen_q;
    logic [15:0]  byteIdx_q;
    logic [15:0]  fetchBlk_q;
    logic [31:0]  fetchOff_q;
    logic         eqSoFar_q;
    logic         greater_q;
    logic         less_q;

    logic         apbWr;
    logic         mapped;
    logic         startCmd;
    logic         paramHit;
    logic [PW-1:0] paramIdx;
    logic [PW-1:0] descBase;
    logic [7:0]   patByte;
    logic         descPass;
    logic         spanned;
    logic         invert;
    logic [7:0]   opcode;

    // Read a big-endian field out of the parameter buffer
    function automatic logic [31:0] get32(input logic [PW-1:0] idx);
        get32 = {paramMem[idx], paramMem[PW'(idx + PW'(1))],
                 paramMem[PW'(idx + PW'(2))], paramMem[PW'(idx + PW'(3))]};
    endfunction

    function automatic logic [15:0] get16(input logic [PW-1:0] idx);
        get16 = {paramMem[idx], paramMem[PW'(idx + PW'(1))]};
    endfunction

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign pready   = 1'b1;
    assign apbWr    = psel && penable && pwrite;
    assign paramHit = (paddr >= `SDCE_REG_PARAM) &&
                      (paddr < 12'(`SDCE_REG_PARAM + 4 * PARAM_BYTES));
    assign paramIdx = PW'((paddr - `SDCE_REG_PARAM) >> 2);
    assign startCmd = apbWr && (paddr == `SDCE_REG_CTRL) &&
                      pwdata[`SDCE_CTRL_START] && !busy_q;
    assign opcode   = cdbOp_q[7:0];
    assign spanned  = cdbOp_q[`SDCE_OP_SPANNED];
    assign invert   = cdbOp_q[`SDCE_OP_INVERT];

    // Address map check
    always_comb
    begin
        unique case (paddr)
            `SDCE_REG_CTRL, `SDCE_REG_CDB_OP, `SDCE_REG_CDB_LBA, `SDCE_REG_CDB_NBLK,
            `SDCE_REG_BLKLEN, `SDCE_REG_STATUS, `SDCE_REG_INFO, `SDCE_REG_CSI,
            `SDCE_REG_NEXT_LBA, `SDCE_REG_NEXT_FLG, `SDCE_REG_EFF_LBA: mapped = 1'b1;
            default: mapped = paramHit && (paddr[1:0] == 2'b00);
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    // Read data multiplexer
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && mapped)
        begin
            unique case (paddr)
                `SDCE_REG_CTRL:     prdata = {30'h0, link_q, 1'b0};
                `SDCE_REG_CDB_OP:   prdata = {16'h0, cdbOp_q};
                `SDCE_REG_CDB_LBA:  prdata = cdbLba_q;
                `SDCE_REG_CDB_NBLK: prdata = {16'h0, cdbNblk_q};
                `SDCE_REG_BLKLEN:   prdata = blkLen_q;
                `SDCE_REG_STATUS:   prdata = {result_q.asc, 3'h0, result_q.valid,
                                              result_q.senseKey, result_q.status,
                                              6'h0, done_q, busy_q};
                `SDCE_REG_INFO:     prdata = info_q;
                `SDCE_REG_CSI:      prdata = csi_q;
                `SDCE_REG_NEXT_LBA: prdata = nextLba_q;
                `SDCE_REG_NEXT_FLG: prdata = {31'h0, nextRel_q};
                `SDCE_REG_EFF_LBA:  prdata = effLba_q;
                default:            prdata = {24'h0, paramMem[paramIdx]};
            endcase
        end
    end

    // Software-written command and configuration registers
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            link_q    <= 1'b0;
            cdbOp_q   <= 16'h0000;
            cdbLba_q  <= 32'h0000_0000;
            cdbNblk_q <= 16'h0000;
            blkLen_q  <= `SDCE_BLKLEN_RESET;
            nextLba_q <= 32'h0000_0000;
            nextRel_q <= 1'b0;
        end
        else if (apbWr && !busy_q)
        begin
            unique case (paddr)
                `SDCE_REG_CTRL:     link_q    <= pwdata[`SDCE_CTRL_LINK];
                `SDCE_REG_CDB_OP:   cdbOp_q   <= pwdata[15:0];
                `SDCE_REG_CDB_LBA:  cdbLba_q  <= pwdata;
                `SDCE_REG_CDB_NBLK: cdbNblk_q <= pwdata[15:0];
                `SDCE_REG_BLKLEN:   blkLen_q  <= pwdata;
                `SDCE_REG_NEXT_LBA: nextLba_q <= pwdata;
                `SDCE_REG_NEXT_FLG: nextRel_q <= pwdata[0];
                default:            ;
            endcase
        end
    end

    // Parameter list buffer, one byte per word, loaded while idle
    always_ff @(posedge clock)
    begin
        if (apbWr && paramHit && mapped && !busy_q)
            paramMem[paramIdx] <= pwdata[7:0];
    end

    // Next command address, relative to the match block when flagged
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            effLba_q <= 32'h0000_0000;
        else
            effLba_q <= nextRel_q ? 32'(info_q + nextLba_q) : nextLba_q;
    end

    // ------------------------------------------------------------------
    // Descriptor evaluation
    // ------------------------------------------------------------------
    assign descBase = PW'(`SDCE_HDR_BYTES + descPtr_q);
    assign patByte  = paramMem[PW'(descBase + PW'(`SDCE_DSC_PATTERN) + PW'(byteIdx_q))];

    // Pass test per opcode and invert flag
    always_comb
    begin
        unique case (opcode)
            `SDCE_OPC_EQUAL: descPass = invert ? !eqSoFar_q : eqSoFar_q;
            `SDCE_OPC_HIGH:  descPass = invert ? !greater_q : greater_q;
            `SDCE_OPC_LOW:   descPass = invert ? !less_q : less_q;
            default:         descPass = 1'b0;
        endcase
    end

    assign mediaReq = (state_q == sdce_pkg::SDCE_FETCH);

    // Media address comes from the fetch cursor registers
    always_comb
    begin
        mediaAddr.lba    = 32'(cdbLba_q + {16'h0, fetchBlk_q});
        mediaAddr.offset = fetchOff_q;
    end

    // ------------------------------------------------------------------
    // Search sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            state_q    <= sdce_pkg::SDCE_IDLE;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            result_q   <= '0;
            info_q     <= 32'h0000_0000;
            csi_q      <= 32'h0000_0000;
            recLen_q   <= 32'h0000_0000;
            numRec_q   <= 32'h0000_0000;
            argLen_q   <= 16'h0000;
            recBlk_q   <= 16'h0000;
            recOff_q   <= 32'h0000_0000;
            recLeft_q  <= 32'h0000_0000;
            descPtr_q  <= 16'h0000;
            disp_q     <= 32'h0000_0000;
            plen_q     <= 16'h0000;
            byteIdx_q  <= 16'h0000;
            fetchBlk_q <= 16'h0000;
            fetchOff_q <= 32'h0000_0000;
            eqSoFar_q  <= 1'b1;
            greater_q  <= 1'b0;
            less_q     <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                sdce_pkg::SDCE_IDLE:
                begin
                    if (startCmd)
                    begin
                        busy_q    <= 1'b1;
                        done_q    <= 1'b0;
                        recLen_q  <= get32(PW'(`SDCE_HDR_RECLEN));
                        recOff_q  <= get32(PW'(`SDCE_HDR_FIRSTOFF));
                        numRec_q  <= get32(PW'(`SDCE_HDR_NUMREC));
                        argLen_q  <= get16(PW'(`SDCE_HDR_ARGLEN));
                        recBlk_q  <= 16'h0000;
                        state_q   <= sdce_pkg::SDCE_CHECK;
                    end
                end
                sdce_pkg::SDCE_CHECK:
                begin
                    recLeft_q <= numRec_q;
                    if (recOff_q > blkLen_q)
                    begin
                        result_q <= '{`SDCE_ST_CHECK, `SDCE_SK_ILLEGAL, 1'b0,
                                      `SDCE_ASC_INV_PARAM};
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                        state_q  <= sdce_pkg::SDCE_IDLE;
                    end
                    else if (cdbNblk_q == 16'h0000 || numRec_q == 32'h0000_0000)
                    begin
                        // Nothing to search is a plain miss, not an error
                        result_q <= '{link_q ? `SDCE_ST_CHECK : `SDCE_ST_GOOD,
                                      `SDCE_SK_NO_SENSE, 1'b0, `SDCE_ASC_NONE};
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                        state_q  <= sdce_pkg::SDCE_IDLE;
                    end
                    else
                        state_q  <= sdce_pkg::SDCE_PLACE;
                end
                sdce_pkg::SDCE_PLACE:
                begin
                    if (recBlk_q >= cdbNblk_q)
                    begin
                        // Block count used up
                        result_q <= '{link_q ? `SDCE_ST_CHECK : `SDCE_ST_GOOD,
                                      `SDCE_SK_NO_SENSE, 1'b0, `SDCE_ASC_NONE};
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                        state_q  <= sdce_pkg::SDCE_IDLE;
                    end
                    else if (spanned && recOff_q >= blkLen_q)
                    begin
                        recOff_q <= 32'(recOff_q - blkLen_q);
                        recBlk_q <= 16'(recBlk_q + 16'h0001);
                    end
                    else if (!spanned && 33'(recOff_q + recLen_q) > 33'(blkLen_q))
                    begin
                        recOff_q <= 32'h0000_0000;
                        recBlk_q <= 16'(recBlk_q + 16'h0001);
                    end
                    else
                    begin
                        descPtr_q <= 16'h0000;
                        state_q   <= sdce_pkg::SDCE_DLOAD;
                    end
                end
                sdce_pkg::SDCE_DLOAD:
                begin
                    if (descPtr_q >= argLen_q)
                    begin
                        // Every descriptor held inside this record
                        result_q <= '{link_q ? `SDCE_ST_INT_MET : `SDCE_ST_COND_MET,
                                      (opcode == `SDCE_OPC_EQUAL && !invert) ?
                                      `SDCE_SK_EQUAL : `SDCE_SK_NO_SENSE,
                                      1'b1, `SDCE_ASC_NONE};
                        info_q   <= 32'(cdbLba_q + {16'h0, recBlk_q});
                        csi_q    <= recOff_q;
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                        state_q  <= sdce_pkg::SDCE_IDLE;
                    end
                    else
                    begin
                        disp_q    <= get32(descBase);
                        plen_q    <= get16(PW'(descBase + PW'(`SDCE_DSC_PLEN)));
                        byteIdx_q <= 16'h0000;
                        eqSoFar_q <= 1'b1;
                        greater_q <= 1'b0;
                        less_q    <= 1'b0;
                        state_q   <= sdce_pkg::SDCE_ADDR;
                    end
                end
                sdce_pkg::SDCE_ADDR:
                begin
                    fetchBlk_q <= recBlk_q;
                    fetchOff_q <= 32'(recOff_q + disp_q + {16'h0, byteIdx_q});
                    if (byteIdx_q >= plen_q)
                        state_q <= sdce_pkg::SDCE_DEVAL;
                    else
                        state_q <= sdce_pkg::SDCE_NORM;
                end
                sdce_pkg::SDCE_NORM:
                begin
                    if (spanned && fetchOff_q >= blkLen_q)
                    begin
                        fetchOff_q <= 32'(fetchOff_q - blkLen_q);
                        fetchBlk_q <= 16'(fetchBlk_q + 16'h0001);
                    end
                    else if (fetchBlk_q >= cdbNblk_q)
                    begin
                        // Record runs past the last block to search
                        result_q <= '{link_q ? `SDCE_ST_CHECK : `SDCE_ST_GOOD,
                                      `SDCE_SK_NO_SENSE, 1'b0, `SDCE_ASC_NONE};
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                        state_q  <= sdce_pkg::SDCE_IDLE;
                    end
                    else
                        state_q <= sdce_pkg::SDCE_FETCH;
                end
                sdce_pkg::SDCE_FETCH:
                begin
                    if (mediaAck)
                    begin
                        // First differing byte decides the magnitude
                        if (eqSoFar_q && mediaData != patByte)
                        begin
                            eqSoFar_q <= 1'b0;
                            greater_q <= mediaData > patByte;
                            less_q    <= mediaData < patByte;
                        end
                        byteIdx_q <= 16'(byteIdx_q + 16'h0001);
                        state_q   <= sdce_pkg::SDCE_ADDR;
                    end
                end
                sdce_pkg::SDCE_DEVAL:
                begin
                    if (descPass)
                    begin
                        descPtr_q <= 16'(descPtr_q + 16'(`SDCE_DSC_PATTERN) + plen_q);
                        state_q   <= sdce_pkg::SDCE_DLOAD;
                    end
                    else
                        state_q   <= sdce_pkg::SDCE_NEXTREC;
                end
                sdce_pkg::SDCE_NEXTREC:
                begin
                    recLeft_q <= 32'(recLeft_q - 32'h0000_0001);
                    if (recLeft_q == 32'h0000_0001)
                    begin
                        // Record count used up
                        result_q <= '{link_q ? `SDCE_ST_CHECK : `SDCE_ST_GOOD,
                                      `SDCE_SK_NO_SENSE, 1'b0, `SDCE_ASC_NONE};
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                        state_q  <= sdce_pkg::SDCE_IDLE;
                    end
                    else
                    begin
                        recOff_q <= 32'(recOff_q + recLen_q);
                        state_q  <= sdce_pkg::SDCE_PLACE;
                    end
                end
            endcase
        end
    end

endmodule

// ### dv/sdce_media_model.sv
// Media model that answers byte fetches of the search engine
`timescale 1ns/1ps
module sdce_media_model (
    input  wire logic                      clock,     // Clock
    input  wire logic                      reset_n,   // Reset, active low
    input  wire logic                      mediaReq,  // Fetch request
    input  wire sdce_pkg::sdce_media_req_t mediaAddr, // Fetch address
    output logic                           mediaAck,  // Answer pulse
    output logic      [7:0]                mediaData  // Fetched byte
);
    logic [1:0] waitCnt_q;
    // Mixes prompt and slow answers; data line toggles outside an answer
    always_ff @(posedge clock)
    begin
        mediaAck  <= 1'b0;
        mediaData <= ~mediaData;
        if (!reset_n)
        begin
            waitCnt_q <= 2'h0;
            mediaData <= 8'h00;
        end
        else if (mediaReq && !mediaAck)
        begin
            waitCnt_q <= waitCnt_q + 2'h1;
            if (waitCnt_q != 2'h0)
            begin
                mediaAck  <= 1'b1;
                mediaData <= mediaAddr.offset[7:0] ^ {mediaAddr.lba[3:0], 4'h0};
            end
        end
    end
endmodule

// ### dv/sdce_search_checker.sv
// Checker of the media port and the APB error answer
`timescale 1ns/1ps
`include "sdce_cfg.svh"
module sdce_search_checker (
    input wire logic                      clock,     // Clock
    input wire logic                      reset_n,   // Reset, active low
    input wire logic                      psel,      // APB select
    input wire logic                      penable,   // APB access
    input wire logic                      pwrite,    // APB write
    input wire logic [11:0]               paddr,     // APB address
    input wire logic [31:0]               pwdata,    // APB write data
    input wire logic [31:0]               prdata,    // APB read data
    input wire logic                      pslverr,   // APB error
    input wire logic                      mediaReq,  // Fetch request
    input wire sdce_pkg::sdce_media_req_t mediaAddr, // Fetch address
    input wire logic                      mediaAck   // Fetch answer
);
    logic [31:0] lba_q, nblk_q, blk_q;
    logic        span_q;
    // Shadow of the search limits written over APB
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            lba_q  <= 32'h0;
            nblk_q <= 32'h0;
            blk_q  <= `SDCE_BLKLEN_RESET;
            span_q <= 1'b0;
        end
        else if (psel && penable && pwrite)
            case (paddr)
                `SDCE_REG_CDB_LBA:  lba_q <= pwdata;
                `SDCE_REG_CDB_NBLK: nblk_q <= {16'h0, pwdata[15:0]};
                `SDCE_REG_BLKLEN:   blk_q <= pwdata;
                `SDCE_REG_CDB_OP:   span_q <= pwdata[`SDCE_OP_SPANNED];
                default:            ;
            endcase
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_addr_hold: assert property (mediaReq && !mediaAck |=> mediaReq && $stable(mediaAddr))
        else $error("fetch moved before its answer");
    a_req_gap: assert property (mediaReq && mediaAck |=> !mediaReq [*2])
        else $error("fetch not released after answer");
    a_req_end: assert property ($fell(mediaReq) |-> $past(mediaAck))
        else $error("fetch withdrawn without answer");
    a_blk_range: assert property (mediaReq |-> mediaAddr.lba - lba_q < nblk_q)
        else $error("fetch outside searched blocks");
    a_no_blocks: assert property (nblk_q == 32'h0 |-> !mediaReq)
        else $error("fetch with zero blocks");
    a_unspan_fit: assert property (mediaReq && !span_q |-> mediaAddr.offset < blk_q)
        else $error("unspanned fetch past block end");
    a_span_fit: assert property (mediaReq && span_q |-> mediaAddr.offset < blk_q)
        else $error("spanned fetch not moved to next block");
    a_bad_addr: assert property (psel && penable && paddr == 12'h102 |-> pslverr && !prdata)
        else $error("unaligned buffer address accepted");
endmodule
bind sdce_search_engine sdce_search_checker u_chk (.clock(clock), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pslverr(pslverr), .mediaReq(mediaReq), .mediaAddr(mediaAddr),
    .mediaAck(mediaAck));

// ### dv/tb_top.sv
// Self-checking bench for the search data command engine
`timescale 1ns/1ps
`include "sdce_cfg.svh"
module tb_top;
    logic                      clock, reset_n, psel, penable, pwrite, pready, pslverr, er;
    logic                      mediaReq, mediaAck;
    logic [11:0]               paddr;
    logic [31:0]               pwdata, prdata, rd;
    logic [7:0]                mediaData;
    sdce_pkg::sdce_media_req_t mediaAddr;
    int                        fail_count = 0, checks_done = 0, cycles = 0;
    sdce_search_engine dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mediaReq(mediaReq), .mediaAddr(mediaAddr), .mediaAck(mediaAck),
        .mediaData(mediaData));
    sdce_media_model u_media (.clock(clock), .reset_n(reset_n), .mediaReq(mediaReq),
        .mediaAddr(mediaAddr), .mediaAck(mediaAck), .mediaData(mediaData));
    // Clock and cycle ceiling
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pb(input int i, input int n, input logic [31:0] v);
        for (int k = 0; k < n; k++)
            apb(1'b1, `SDCE_REG_PARAM + 12'(4 * (i + k)), {24'h0, v[8 * (n - 1 - k) +: 8]});
    endtask
    // One command: descriptor is {displacement, length, pattern}, length 0 = absent
    task automatic run(input logic [31:0] op, lk, nb, fo, nr, d0, d1, st, sk, v, inf, csi);
        int          p;
        logic [31:0] dl [2];
        dl = '{d0, d1};
        p = `SDCE_HDR_BYTES;
        pb(`SDCE_HDR_RECLEN, 4, 32'h4);
        pb(`SDCE_HDR_FIRSTOFF, 4, fo);
        pb(`SDCE_HDR_NUMREC, 4, nr);
        for (int j = 0; j < 2; j++)
            if (dl[j][23:16] != 8'h00)
            begin
                pb(p, 4, {24'h0, dl[j][31:24]});
                pb(p + `SDCE_DSC_PLEN, 2, {24'h0, dl[j][23:16]});
                pb(p + `SDCE_DSC_PATTERN, dl[j][23:16], {16'h0, dl[j][15:0]});
                p += `SDCE_DSC_PATTERN + dl[j][23:16];
            end
        pb(`SDCE_HDR_ARGLEN, 2, 32'(p - `SDCE_HDR_BYTES));
        apb(1'b1, `SDCE_REG_CDB_OP, op);
        apb(1'b1, `SDCE_REG_CDB_NBLK, nb);
        apb(1'b1, `SDCE_REG_CTRL, {30'h0, lk[0], 1'b1});
        do apb(1'b0, `SDCE_REG_STATUS, 32'h0); while (rd[1] !== 1'b1);
        cmp("status", 32'(rd[15:8]), st);
        cmp("sense key", 32'(rd[19:16]), sk);
        cmp("valid", 32'(rd[20]), v);
        cmp("asc", 32'(rd[31:24]), (st == 32'h2 && sk == 32'h5) ? 32'h26 : 32'h0);
        if (v[0])
        begin
            apb(1'b0, `SDCE_REG_INFO, 32'h0);
            cmp("info", rd, inf);
            apb(1'b0, `SDCE_REG_CSI, 32'h0);
            cmp("csi", rd, csi);
        end
    endtask
    // Main sequence; block length 16, record length 4, byte = offset xor block*16
    initial
    begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        apb(1'b0, 12'h102, 32'h0);
        cmp("err data", rd, 32'h0);
        cmp("pslverr", 32'(er), 32'h1);
        apb(1'b1, `SDCE_REG_BLKLEN, 32'h10);
        run(32'h31, 0, 2, 0, 8, 32'h01010009, 0, 32'h04, 32'hC, 1, 0, 8);
        run(32'h31, 1, 2, 0, 8, 32'h01010015, 0, 32'h14, 32'hC, 1, 1, 4);
        apb(1'b1, `SDCE_REG_NEXT_LBA, 32'h3);
        apb(1'b1, `SDCE_REG_NEXT_FLG, 32'h1);
        apb(1'b0, `SDCE_REG_EFF_LBA, 32'h0);
        cmp("next lba", rd, 32'h4);
        run(32'h31, 1, 2, 0, 2, 32'h01010009, 0, 32'h02, 0, 0, 0, 0);
        run(32'h31, 0, 0, 0, 8, 32'h01010009, 0, 0, 0, 0, 0, 0);
        run(32'h31, 0, 1, 0, 8, 32'h01010015, 0, 0, 0, 0, 0, 0);
        run(32'h31, 0, 2, 17, 8, 32'h01010009, 0, 32'h02, 5, 0, 0, 0);
        run(32'h231, 0, 2, 2, 8, 32'h02010010, 0, 32'h04, 32'hC, 1, 0, 14);
        run(32'h31, 0, 2, 2, 8, 32'h02010012, 0, 32'h04, 32'hC, 1, 1, 0);
        run(32'h30, 0, 2, 0, 8, 32'h000207FF, 0, 32'h04, 0, 1, 0, 8);
        run(32'h1030, 0, 2, 4, 8, 32'h00020405, 0, 32'h04, 0, 1, 0, 4);
        run(32'h32, 0, 2, 8, 8, 32'h00020808, 0, 0, 0, 0, 0, 0);
        run(32'h1032, 0, 2, 4, 8, 32'h00020809, 0, 32'h04, 0, 1, 0, 8);
        run(32'h1031, 0, 2, 0, 8, 32'h00010000, 0, 32'h04, 0, 1, 0, 4);
        run(32'h31, 0, 2, 0, 8, 32'h00020809, 32'h0201000A, 32'h04, 32'hC, 1, 0, 8);
        run(32'h31, 0, 2, 0, 8, 32'h00020809, 32'h0201000B, 0, 0, 0, 0, 0);
        finish_test();
    end
endmodule
